// >>> common/dsc_pkg.sv
// Package: constants and types shared by the memory controller files
// Assumes a 20 MHz clock and an AHB-Lite register port
package dsc_pkg;
	// Clock rate and time figures
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned PWRUP_WAIT_US = 200;
	localparam int unsigned PWRUP_WAIT_CYC = (PWRUP_WAIT_US * (CLK_HZ / 1000000));
	localparam int unsigned DLL_LOCK_CYC = 200;
	localparam int unsigned MODE_WRITE_GAP_CYC = 2;
	localparam int unsigned PRECHARGE_CYC = 1;
	localparam int unsigned REFRESH_CYC = 2;
	localparam int unsigned ACTIVATE_CYC = 1;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_MODE = 8'h08;
	localparam logic [7:0] OFS_EXT = 8'h0C;
	localparam logic [7:0] OFS_CMD = 8'h10;
	// Control register fields
	localparam int CTRL_START = 0;
	// Command register fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_BANK_LSB = 4;
	localparam int CMD_ADDR_LSB = 8;
	// Reset values
	localparam logic [12:0] MODE_RESET = 13'h0032;
	localparam logic [14:0] EXT_RESET = 15'h2000;
	// Mode register fields
	localparam int MR_BL_LSB = 0;
	localparam int MR_BT = 3;
	localparam int MR_CL_LSB = 4;
	localparam int MR_TEST = 7;
	localparam int MR_DLL_RESET = 8;
	localparam logic [12:0] MR_LEGAL_MASK = 13'h017F;
	// Extended mode register fields
	localparam int EMR_DLL_OFF = 0;
	localparam logic [14:0] EMR_LEGAL_MASK = 15'h2043;
	localparam int EMR_BA0 = 13;
	// Pin command encodings {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] PIN_DESEL = 4'hF;
	localparam logic [3:0] PIN_NOP = 4'h7;
	localparam logic [3:0] PIN_MODE = 4'h0;
	localparam logic [3:0] PIN_REFRESH = 4'h1;
	localparam logic [3:0] PIN_ACTIVE = 4'h3;
	localparam logic [3:0] PIN_READ = 4'h5;
	localparam logic [3:0] PIN_WRITE = 4'h4;
	localparam logic [3:0] PIN_PRECH = 4'h2;
	localparam logic [3:0] PIN_BSTOP = 4'h6;
	// Software command codes
	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_ACTIVE = 4'h1,
		OP_READ = 4'h2,
		OP_WRITE = 4'h3,
		OP_PRECH = 4'h4,
		OP_PRECH_ALL = 4'h5,
		OP_REFRESH = 4'h6,
		OP_MODE = 4'h7,
		OP_EXT = 4'h8,
		OP_BSTOP = 4'h9
	} dsc_op_t;
	// Status bits
	localparam int ST_READY = 0;
	localparam int ST_BUSY = 1;
	localparam int ST_REFUSED = 2;
	localparam int ST_OPEN_LSB = 4;
endpackage

// >>> common/dsc_cmd_if.sv
// Interface: command request from the sequencer to the pin driver
// Assumes both ends share the module clock
interface dsc_cmd_if;
	import dsc_pkg::*;
	logic valid;
	logic ready;
	logic [3:0] pins;
	logic [1:0] bank;
	logic [12:0] addr;
	logic [7:0] wait_cyc;
	modport seq (output valid, pins, bank, addr, wait_cyc, input ready);
	modport drv (input valid, pins, bank, addr, wait_cyc, output ready);
endinterface

// >>> design/dsc_pin_driver.sv
// Pin driver: registers one command onto the memory pins and holds off
// Assumes one request at a time over the command interface
module dsc_pin_driver
	import dsc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Command request
	dsc_cmd_if.drv cmd,
	// Memory pins
	output logic [3:0] pins,
	output logic [1:0] bank,
	output logic [12:0] addr
);
	typedef struct packed {
		logic [3:0] pins;
		logic [1:0] bank;
		logic [12:0] addr;
		logic [7:0] hold;
	} dsc_drv_t;
	dsc_drv_t s_q, s_d;

	// Ready when the previous command's gap has run out
	assign cmd.ready = (s_q.hold == 8'h00);

	// Drive the command one cycle, then NOP through the gap
	always_comb
	begin
		s_d = s_q;
		s_d.pins = PIN_NOP;
		if (s_q.hold != 8'h00)
		begin
			s_d.hold = s_q.hold - 8'h01;
		end
		if (cmd.valid && cmd.ready)
		begin
			s_d.pins = cmd.pins;
			s_d.bank = cmd.bank;
			s_d.addr = cmd.addr;
			s_d.hold = cmd.wait_cyc;
		end
	end

	// State register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s_q <= '{pins: PIN_DESEL, bank: 2'h0, addr: 13'h0000, hold: 8'h00};
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign pins = s_q.pins;
	assign bank = s_q.bank;
	assign addr = s_q.addr;
endmodule

// >>> design/dsc_ctrl.sv
// Memory controller top: power-up sequence, command issue, AHB-Lite registers
// Assumes one AHB-Lite master, word transfers, 20 MHz REF_CLK
module dsc_ctrl
	import dsc_pkg::*;
#(
	parameter int unsigned PWRUP_CYC = PWRUP_WAIT_CYC
)
(
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic HREADY,
	input wire logic [31:0] HWDATA,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// Memory command pins
	output logic CKE,
	output logic CS_N,
	output logic RAS_N,
	output logic CAS_N,
	output logic WE_N,
	output logic [1:0] BA,
	output logic [12:0] A,
	output logic [1:0] DM,
	output logic [1:0] DQS_OE
);
	// Power-up count must fit the 24-bit wait counter
	if (PWRUP_CYC < 1 || PWRUP_CYC > 32'h00FFFFFF)
	begin
		$error("PWRUP_CYC out of range");
	end

	typedef enum logic [3:0] {
		S_POWER, S_CKE, S_PRE1, S_EXT, S_MRS_RST, S_LOCK, S_PRE2,
		S_REF1, S_REF2, S_MRS_RUN, S_IDLE
	} dsc_state_t;

	typedef struct packed {
		dsc_state_t st;
		logic [23:0] cnt;
		logic [7:0] dll_cnt;
		logic cke;
		logic started;
		logic [3:0] open;
		logic [12:0] mode;
		logic [14:0] ext;
		logic cmd_pend;
		logic [24:0] cmd;
		logic refused;
		logic wr_addr_ok;
		logic rd_pend;
		logic [7:0] rd_ofs;
		logic [7:0] wr_ofs;
		logic [31:0] rdata;
	} dsc_top_t;
	dsc_top_t s_q, s_d;

	dsc_cmd_if cif ();
	logic [3:0] pins;
	logic [3:0] op;
	logic [1:0] cbank;
	logic [12:0] caddr;
	logic idle_all;
	logic take;

	dsc_pin_driver u_drv (
		.clk(REF_CLK),
		.rst(RST),
		.cmd(cif),
		.pins(pins),
		.bank(BA),
		.addr(A)
	);

	// Field views of the pending software command
	assign op = s_q.cmd[CMD_OP_LSB +: 4];
	assign cbank = s_q.cmd[CMD_BANK_LSB +: 2];
	assign caddr = s_q.cmd[CMD_ADDR_LSB +: 13];
	assign idle_all = (s_q.open == 4'h0);
	assign take = HSEL && HREADY && HTRANS[1];

	// ----------------------------------------------------------------
	// Sequencer and register file
	// ----------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		cif.valid = 1'b0;
		cif.pins = PIN_NOP;
		cif.bank = 2'h0;
		cif.addr = 13'h0000;
		cif.wait_cyc = 8'h00;
		if (s_q.cnt != 24'h000000)
		begin
			s_d.cnt = s_q.cnt - 24'h000001;
		end
		if (s_q.dll_cnt != 8'h00)
		begin
			s_d.dll_cnt = s_q.dll_cnt - 8'h01;
		end
		case (s_q.st)
			S_POWER:
			begin
				// CKE low for the whole power-up wait
				if (s_q.started && s_q.cnt == 24'h000000)
				begin
					s_d.cke = 1'b1;
					s_d.st = S_CKE;
				end
			end
			S_CKE:
			begin
				s_d.st = S_PRE1;
			end
			S_PRE1, S_PRE2:
			begin
				cif.valid = 1'b1;
				cif.pins = PIN_PRECH;
				cif.addr = 13'h0400;
				cif.wait_cyc = 8'(PRECHARGE_CYC);
				if (cif.ready)
				begin
					s_d.open = 4'h0;
					s_d.st = (s_q.st == S_PRE1) ? S_EXT : S_REF1;
				end
			end
			S_EXT:
			begin
				cif.valid = 1'b1;
				cif.pins = PIN_MODE;
				cif.bank = 2'h1;
				// Only legal fields pass, DLL forced on
				cif.addr = s_q.ext[12:0] & EMR_LEGAL_MASK[12:0] & ~13'h0001;
				cif.wait_cyc = 8'(MODE_WRITE_GAP_CYC);
				if (cif.ready)
				begin
					s_d.dll_cnt = 8'(DLL_LOCK_CYC);
					s_d.st = S_MRS_RST;
				end
			end
			S_MRS_RST, S_MRS_RUN:
			begin
				cif.valid = 1'b1;
				cif.pins = PIN_MODE;
				cif.bank = 2'h0;
				// DLL reset bit only on the first mode write, cleared on the last
				cif.addr = (s_q.mode & MR_LEGAL_MASK & ~(13'h1 << MR_TEST)
					& ~(13'h1 << MR_DLL_RESET))
					| ((s_q.st == S_MRS_RST) ? (13'h1 << MR_DLL_RESET) : 13'h0000);
				cif.wait_cyc = 8'(MODE_WRITE_GAP_CYC);
				if (cif.ready)
				begin
					s_d.cnt = 24'(DLL_LOCK_CYC);
					s_d.st = (s_q.st == S_MRS_RST) ? S_LOCK : S_IDLE;
				end
			end
			S_LOCK:
			begin
				if (s_q.cnt == 24'h000000)
				begin
					s_d.st = S_PRE2;
				end
			end
			S_REF1, S_REF2:
			begin
				cif.valid = 1'b1;
				cif.pins = PIN_REFRESH;
				cif.wait_cyc = 8'(REFRESH_CYC);
				if (cif.ready)
				begin
					s_d.st = (s_q.st == S_REF1) ? S_REF2 : S_MRS_RUN;
				end
			end
			S_IDLE:
			begin
				if (s_q.cmd_pend)
				begin
					cif.bank = cbank;
					cif.addr = caddr;
					cif.wait_cyc = 8'(ACTIVATE_CYC);
					s_d.refused = 1'b0;
					case (op)
						OP_ACTIVE:
						begin
							cif.pins = PIN_ACTIVE;
							cif.valid = !s_q.open[cbank];
						end
						OP_READ:
						begin
							cif.pins = PIN_READ;
							cif.valid = s_q.open[cbank] && (s_q.dll_cnt == 8'h00);
						end
						OP_WRITE:
						begin
							// Write with A10 holds off further column commands
							cif.pins = PIN_WRITE;
							cif.valid = s_q.open[cbank];
							cif.wait_cyc = caddr[10] ? 8'(4 + PRECHARGE_CYC) : 8'h01;
						end
						OP_PRECH:
						begin
							cif.pins = PIN_PRECH;
							cif.addr = caddr & ~13'h0400;
							cif.valid = 1'b1;
						end
						OP_PRECH_ALL:
						begin
							cif.pins = PIN_PRECH;
							cif.addr = 13'h0400;
							cif.valid = 1'b1;
						end
						OP_REFRESH:
						begin
							cif.pins = PIN_REFRESH;
							cif.valid = idle_all;
						end
						OP_MODE:
						begin
							cif.pins = PIN_MODE;
							cif.bank = 2'h0;
							cif.addr = caddr & MR_LEGAL_MASK & ~(13'h1 << MR_TEST);
							cif.wait_cyc = 8'(MODE_WRITE_GAP_CYC);
							cif.valid = idle_all && s_q.cke;
						end
						OP_EXT:
						begin
							cif.pins = PIN_MODE;
							cif.bank = 2'h1;
							cif.addr = caddr & EMR_LEGAL_MASK[12:0];
							cif.wait_cyc = 8'(MODE_WRITE_GAP_CYC);
							cif.valid = idle_all && s_q.cke;
						end
						OP_BSTOP:
						begin
							cif.pins = PIN_BSTOP;
							cif.valid = 1'b1;
						end
						default:
						begin
							cif.pins = PIN_NOP;
							cif.valid = 1'b1;
						end
					endcase
					if (cif.valid && cif.ready)
					begin
						s_d.cmd_pend = 1'b0;
						if (op == OP_ACTIVE)
						begin
							s_d.open[cbank] = 1'b1;
						end
						if (op == OP_PRECH || (op == OP_WRITE && caddr[10])
							|| (op == OP_READ && caddr[10]))
						begin
							s_d.open[cbank] = 1'b0;
						end
						if (op == OP_PRECH_ALL)
						begin
							s_d.open = 4'h0;
						end
						if (op == OP_EXT && !caddr[EMR_DLL_OFF])
						begin
							s_d.dll_cnt = 8'(DLL_LOCK_CYC);
						end
					end
					else if (cif.ready)
					begin
						// Illegal in present state: drop and flag
						s_d.cmd_pend = 1'b0;
						s_d.refused = 1'b1;
					end
				end
			end
			default:
			begin
				s_d.st = S_POWER;
			end
		endcase

		// Bus address phase capture
		if (take)
		begin
			s_d.wr_addr_ok = HWRITE;
			s_d.wr_ofs = HADDR[7:0];
			s_d.rd_pend = !HWRITE;
			s_d.rd_ofs = HADDR[7:0];
		end
		else
		begin
			s_d.wr_addr_ok = 1'b0;
			s_d.rd_pend = 1'b0;
		end

		// Data phase write
		if (s_q.wr_addr_ok)
		begin
			if (s_q.wr_ofs == OFS_CTRL)
			begin
				if (HWDATA[CTRL_START] && s_q.st == S_POWER)
				begin
					s_d.started = 1'b1;
					s_d.cnt = 24'(PWRUP_CYC);
				end
			end
			else if (s_q.wr_ofs == OFS_MODE)
			begin
				s_d.mode = HWDATA[12:0];
			end
			else if (s_q.wr_ofs == OFS_EXT)
			begin
				s_d.ext = HWDATA[14:0];
			end
			else if (s_q.wr_ofs == OFS_CMD && !s_q.cmd_pend && s_q.st == S_IDLE)
			begin
				s_d.cmd = HWDATA[24:0];
				s_d.cmd_pend = 1'b1;
			end
		end

		// Read data registered for the data phase
		s_d.rdata = 32'h00000000;
		if (take && !HWRITE)
		begin
			if (HADDR[7:0] == OFS_STATUS)
			begin
				s_d.rdata[ST_READY] = (s_d.st == S_IDLE);
				s_d.rdata[ST_BUSY] = s_d.cmd_pend;
				s_d.rdata[ST_REFUSED] = s_d.refused;
				s_d.rdata[ST_OPEN_LSB +: 4] = s_d.open;
			end
			else if (HADDR[7:0] == OFS_MODE)
			begin
				s_d.rdata[12:0] = s_q.mode;
			end
			else if (HADDR[7:0] == OFS_EXT)
			begin
				s_d.rdata[14:0] = s_q.ext;
			end
			else if (HADDR[7:0] == OFS_CMD)
			begin
				s_d.rdata[24:0] = s_q.cmd;
			end
		end
	end

	// State register
	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
		begin
			s_q <= '{st: S_POWER, cnt: 24'h000000, dll_cnt: 8'h00, cke: 1'b0, started: 1'b0,
				open: 4'h0, mode: MODE_RESET, ext: EXT_RESET, cmd_pend: 1'b0, cmd: 25'h0000000,
				refused: 1'b0, wr_addr_ok: 1'b0, rd_pend: 1'b0, rd_ofs: 8'h00,
				wr_ofs: 8'h00, rdata: 32'h00000000};
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign HRDATA = s_q.rdata;
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign CKE = s_q.cke;
	assign {CS_N, RAS_N, CAS_N, WE_N} = s_q.cke ? pins : PIN_NOP;
	// No write data path: mask high masks any stray strobe edge
	assign DM = 2'h3;
	assign DQS_OE = 2'h0;
endmodule

// >>> tb/dsc_ctrl_properties.sv
// Checker: pin command timing of the memory controller
// Assumes bind onto dsc_ctrl, one clock domain
module dsc_ctrl_properties
	import dsc_pkg::*;
#(
	parameter int unsigned PWRUP_CYC = PWRUP_WAIT_CYC
)
(
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST,
	// Bus answer
	input wire logic HREADYOUT,
	input wire logic HRESP,
	// Memory pins
	input wire logic CKE,
	input wire logic CS_N,
	input wire logic RAS_N,
	input wire logic CAS_N,
	input wire logic WE_N,
	input wire logic [1:0] BA,
	input wire logic [12:0] A
);
	timeunit 1ns;
	timeprecision 1ns;
	// --------
	// Decode and quiet counters
	// --------
	logic [3:0] pin_cmd;
	logic exe;
	logic mode;
	logic [7:0] lock_q;
	logic [7:0] rdw_q;
	assign pin_cmd = {CS_N, RAS_N, CAS_N, WE_N};
	assign exe = !CS_N && pin_cmd != PIN_NOP;
	assign mode = pin_cmd == PIN_MODE;
	// Quiet periods after DLL reset and DLL enable
	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
		begin
			lock_q <= 8'h00;
			rdw_q <= 8'h00;
		end
		else
		begin
			lock_q <= (mode && !BA[0] && A[8]) ? 8'hC7 : lock_q - {7'h00, lock_q != 8'h00};
			rdw_q <= (mode && BA[0] && !A[0]) ? 8'hC7 : rdw_q - {7'h00, rdw_q != 8'h00};
		end
	end
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (RST);
	// --------
	// Assertions
	// --------
	a_bus_okay: assert property (HREADYOUT && !HRESP)
		else $error("bus answer not zero-wait OKAY");
	a_cke_first: assert property (exe |-> CKE)
		else $error("command with clock enable low");
	a_cke_holds: assert property (CKE |=> CKE)
		else $error("clock enable dropped");
	a_mode_gap: assert property (mode |=> (!exe) [*2])
		else $error("command too soon after mode write");
	a_mode_cke: assert property (mode |-> CKE && $past(CKE))
		else $error("mode write without clock enable settled");
	a_mode_fields: assert property (mode && BA == 2'h0 |-> !A[7] && A[12:9] == 4'h0)
		else $error("mode write with test or reserved bits set");
	a_ext_fields: assert property (mode && BA[0] |-> ({BA, A} & ~EMR_LEGAL_MASK) == 15'h0000)
		else $error("extended write with reserved bits set");
	a_dll_lock: assert property (lock_q != 8'h00 |-> !exe)
		else $error("command during DLL lock time");
	a_read_lock: assert property (rdw_q != 8'h00 |-> pin_cmd != PIN_READ)
		else $error("read too soon after DLL enable");
	c_dll_reset: cover property (mode && !BA[0] && A[8]);
	c_ext_write: cover property (mode && BA[0]);
	c_refresh: cover property (pin_cmd == PIN_REFRESH);
	c_burst_stop: cover property (pin_cmd == PIN_BSTOP);
endmodule

// >>> tb/dsc_sdram_model.sv
// Device model: mode registers, bank state and command order checks
// Assumes commands sampled on the rising clock edge; no reset pin
module dsc_sdram_model
	import dsc_pkg::*;
(
	// Clock
	input wire logic clk,
	// Command pins
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [1:0] ba,
	input wire logic [12:0] a,
	input wire logic [1:0] dm,
	// Observed state
	output logic [12:0] mode_q,
	output logic [14:0] ext_q,
	output logic [3:0] open_q,
	output logic init_ok,
	output logic [7:0] err_q
);
	timeunit 1ns;
	timeprecision 1ns;
	// --------
	// Command decode
	// --------
	logic [3:0] cmd;
	logic [2:0] step_q;
	logic [7:0] gap_q;
	logic [7:0] rdw_q;
	logic [7:0] apw_q;
	logic ok;
	int e;
	assign cmd = {cs_n, ras_n, cas_n, we_n};
	assign init_ok = step_q == 3'h7;
	// Contents undefined until programmed
	initial
	begin
		mode_q = 'x;
		ext_q = 'x;
		{open_q, err_q, step_q, gap_q, rdw_q, apw_q} = '0;
	end
	// No DQ or DQS driven; DM input not used
	always @(posedge clk)
	begin
		e = 0;
		gap_q <= gap_q - {7'h00, gap_q != 8'h00};
		rdw_q <= rdw_q - {7'h00, rdw_q != 8'h00};
		apw_q <= apw_q - {7'h00, apw_q != 8'h00};
		if (!cs_n && cmd != PIN_NOP)
		begin
			if (!cke || gap_q != 8'h00) e++;
			case (step_q)
				3'h0, 3'h3: ok = cmd == PIN_PRECH && a[10];
				3'h1: ok = cmd == PIN_MODE && ba == 2'h1 && !a[0];
				3'h2: ok = cmd == PIN_MODE && ba == 2'h0 && a[8];
				3'h4, 3'h5: ok = cmd == PIN_REFRESH;
				3'h6: ok = cmd == PIN_MODE && ba == 2'h0 && !a[8];
				default: ok = 1'b1;
			endcase
			if (!ok) e++;
			if (step_q != 3'h7) step_q <= step_q + 3'h1;
			case (cmd)
				PIN_MODE:
				begin
					if (open_q != 4'h0) e++;
					gap_q <= 8'h01;
					if (!ba[0])
					begin
						mode_q <= a;
						if (a[7] || a[12:9] != 4'h0) e++;
						if (a[8]) gap_q <= 8'hC7;
					end
					else
					begin
						ext_q <= {ba, a};
						if (({ba, a} & ~EMR_LEGAL_MASK) != 15'h0000) e++;
						if (!a[0]) rdw_q <= 8'hC7;
					end
				end
				PIN_ACTIVE:
				begin
					if (open_q[ba] || apw_q != 8'h00) e++;
					open_q[ba] <= 1'b1;
				end
				PIN_READ, PIN_WRITE:
				begin
					if (!open_q[ba] || (cmd == PIN_READ && rdw_q != 8'h00)) e++;
					if (apw_q != 8'h00) e++;
					if (a[10]) open_q[ba] <= 1'b0;
					// Burst plus precharge allowance after a self-closing write
					if (cmd == PIN_WRITE && a[10]) apw_q <= 8'h04;
				end
				PIN_PRECH: if (a[10]) open_q <= 4'h0; else open_q[ba] <= 1'b0;
				PIN_REFRESH: if (open_q != 4'h0) e++;
				default: ok = 1'b1;
			endcase
		end
		err_q <= err_q + e[7:0];
	end
endmodule

// >>> tb/tb_top.sv
// Testbench: drives the controller over AHB-Lite, checks status and device model
// Assumes dsc_ctrl, the device model and the checker compiled before
module tb_top
	import dsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hr_q = 32'h0;
	logic [31:0] rd;
	logic [3:0] open_e;
	wire logic [31:0] hrdata;
	wire logic hready, hresp, cke, cs_n, ras_n, cas_n, we_n, m_init;
	wire logic [1:0] ba, dm, dqs_oe;
	wire logic [12:0] a, m_mode;
	wire logic [14:0] m_ext;
	wire logic [3:0] m_open;
	wire logic [7:0] m_err;
	int fail_count = 0;
	int checks_done = 0;
	dsc_ctrl #(.PWRUP_CYC(10)) dut (.REF_CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HREADY(hready), .HWDATA(hwdata),
		.HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .CKE(cke), .CS_N(cs_n),
		.RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .BA(ba), .A(a), .DM(dm), .DQS_OE(dqs_oe));
	dsc_sdram_model mem (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
		.we_n(we_n), .ba(ba), .a(a), .dm(dm), .mode_q(m_mode), .ext_q(m_ext),
		.open_q(m_open), .init_ok(m_init), .err_q(m_err));
	// Clock and read data sampled at the data-phase edge
	initial forever #25 clk = ~clk;
	always @(posedge clk) hr_q <= hrdata;
	// --------
	// Tasks
	// --------
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic edge_ready;
		int n;
		n = 0;
		@(posedge clk);
		while (hready !== 1'b1 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 20) begin fail_count++; close_out(); end
	endtask
	task automatic bus(input logic w, input logic [7:0] ofs, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, ofs};
		hwrite <= w;
		edge_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		edge_ready();
		#1;
		rd = hr_q;
	endtask
	task automatic poll(input int b, input logic want, input int lim);
		int n;
		n = 0;
		do begin bus(1'b0, OFS_STATUS, 32'h0); n++; end
		while (rd[b] !== want && n < lim);
		if (rd[b] !== want) begin fail_count++; close_out(); end
	endtask
	task automatic cmd(input logic [3:0] op, input logic [1:0] bk, input logic [12:0] ad,
		input logic refused);
		bus(1'b1, OFS_CMD, {11'h0, ad, 2'h0, bk, op});
		@(posedge clk);
		#1;
		poll(ST_BUSY, 1'b0, 50);
		chk({31'h0, rd[ST_REFUSED]}, {31'h0, refused});
		chk({28'h0, rd[7:4]}, {28'h0, open_e});
		chk({28'h0, m_open}, {28'h0, open_e});
	endtask
	// --------
	// Main sequence
	// --------
	initial
	begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk({31'h0, cke}, 32'h0);
		bus(1'b0, OFS_MODE, 32'h0);
		chk(rd, {19'h0, MODE_RESET});
		bus(1'b0, OFS_EXT, 32'h0);
		chk(rd, {17'h0, EXT_RESET});
		bus(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, OFS_MODE, 32'h1FA3);
		bus(1'b1, OFS_EXT, 32'h7FFF);
		chk({31'h0, cke}, 32'h0);
		bus(1'b1, OFS_CTRL, 32'h1);
		chk({31'h0, cke}, 32'h0);
		poll(ST_READY, 1'b1, 400);
		chk({31'h0, m_init}, 32'h1);
		chk({19'h0, m_mode}, 32'h23);
		chk({17'h0, m_ext}, 32'h2042);
		$display("test init done");
		open_e = 4'h0;
		for (int b = 0; b < 4; b++)
		begin
			open_e[b] = 1'b1;
			cmd(OP_ACTIVE, b[1:0], 13'h0, 1'b0);
		end
		cmd(OP_ACTIVE, 2'h1, 13'h0, 1'b1);
		cmd(OP_MODE, 2'h0, 13'h0, 1'b1);
		cmd(OP_REFRESH, 2'h0, 13'h0, 1'b1);
		cmd(OP_READ, 2'h2, 13'h4, 1'b0);
		open_e[3] = 1'b0;
		cmd(OP_WRITE, 2'h3, 13'h0408, 1'b0);
		cmd(OP_BSTOP, 2'h0, 13'h0, 1'b0);
		open_e[1] = 1'b0;
		cmd(OP_PRECH, 2'h1, 13'h0, 1'b0);
		cmd(OP_READ, 2'h1, 13'h0, 1'b1);
		open_e = 4'h0;
		cmd(OP_PRECH_ALL, 2'h1, 13'h0400, 1'b0);
		cmd(OP_REFRESH, 2'h0, 13'h0, 1'b0);
		cmd(OP_NOP, 2'h0, 13'h0, 1'b0);
		$display("test banks done");
		bus(1'b1, OFS_MODE, 32'h62);
		cmd(OP_MODE, 2'h0, 13'h0062, 1'b0);
		chk({19'h0, m_mode}, 32'h62);
		bus(1'b1, OFS_EXT, 32'h2002);
		cmd(OP_EXT, 2'h0, 13'h0002, 1'b0);
		chk({17'h0, m_ext}, 32'h2002);
		open_e = 4'h1;
		cmd(OP_ACTIVE, 2'h0, 13'h0, 1'b0);
		cmd(OP_READ, 2'h0, 13'h0, 1'b1);
		chk({24'h0, m_err}, 32'h0);
		chk({30'h0, dqs_oe}, 32'h0);
		chk({30'h0, dm}, 32'h3);
		$display("test modes done");
		close_out();
	end
endmodule
bind dsc_ctrl dsc_ctrl_properties #(.PWRUP_CYC(PWRUP_CYC)) props (.REF_CLK(REF_CLK), .RST(RST),
	.HREADYOUT(HREADYOUT), .HRESP(HRESP), .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N),
	.CAS_N(CAS_N), .WE_N(WE_N), .BA(BA), .A(A));
